// ### design/nand_host.sv
// Functional notes
// R1: Command, address and data share one two-way byte bus; host drives writes, releases for reads.
// R2: Device is sequential; host moves one byte per strobe, one transfer at a time.
// R3: Chip select low enables the device; high deselects it.
// R4: Device enters standby when chip select rises in a read while not busy.
// R5: Raising chip select while busy does not stop the device's operation.
// R6: Each read strobe fall makes the device drive the next byte after a delay.
// R7: Each read strobe fall advances the device column counter by one.
// R8: Device captures the bus byte at the rising edge of the write strobe.
// R9: Command latch enable high during the write strobe marks a command byte.
// R10: Address latch enable high during the write strobe marks an address byte.
// R11: Write protect low stops the device from programming or erasing.
// R12: Host keeps write protect low through power-up and power-down.
// R13: Ready/busy is open drain; the host side supplies the pull-up.
// R14: Ready/busy low while an internal read, program or erase runs.
// R15: Ready/busy released high when the internal operation ends.
// R16: Never both latch enables at once; neither set means a data byte.
`timescale 1ns/1ps
`default_nettype none

module nand_host
	import nand_host_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic       req_valid,
	output logic            req_ready,
	input  wire op_kind_e   req_kind,
	input  wire logic [7:0] req_byte,
	output logic            rd_valid,
	output logic [7:0]      rd_data,
	input  wire logic       chip_hold,
	input  wire logic       write_allow,
	output logic            busy,
	output logic [7:0]      shared_io_bus_out,
	input  wire logic [7:0] shared_io_bus_in,
	output logic            shared_io_bus_oe_n,
	output logic            chip_sel_n,
	output logic            read_strobe_n,
	output logic            write_strobe_n,
	output logic            cmd_latch,
	output logic            addr_latch,
	output logic            write_prot_n,
	input  wire logic       ready_busy_n
);

	state_e       state_q;
	state_e       state_d;
	op_kind_e     kind_q;
	op_kind_e     kind_d;
	logic [7:0]   io_out_q;
	logic [7:0]   io_out_d;
	logic         io_oe_n_q;
	logic         io_oe_n_d;
	logic         ce_n_q;
	logic         ce_n_d;
	logic         rd_stb_n_q;
	logic         rd_stb_n_d;
	logic         we_n_q;
	logic         we_n_d;
	logic         cle_q;
	logic         cle_d;
	logic         ale_q;
	logic         ale_d;
	logic         rd_valid_q;
	logic         rd_valid_d;
	logic [7:0]   rd_data_q;
	logic [7:0]   rd_data_d;
	logic         wp_n_q;
	logic         wp_n_d;
	logic         busy_q;
	logic         busy_d;
	logic         tmr_load;
	logic [TIMER_W-1:0] tmr_val;
	logic         tmr_expired;

	phase_timer #(
		.W (TIMER_W)
	) u_phase_timer (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.load     (tmr_load),
		.load_val (tmr_val),
		.expired  (tmr_expired)
	);

	// One transfer at a time keeps the bus strictly time-multiplexed.
	assign req_ready = (state_q == ST_IDLE); // R2

	always_comb begin
		state_d    = state_q;
		kind_d     = kind_q;
		io_out_d   = io_out_q;
		io_oe_n_d  = io_oe_n_q;
		rd_stb_n_d = rd_stb_n_q;
		we_n_d     = we_n_q;
		cle_d      = cle_q;
		ale_d      = ale_q;
		rd_valid_d = 1'b0;
		rd_data_d  = rd_data_q;
		tmr_load   = 1'b0;
		tmr_val    = SETUP_LOAD;
		unique case (state_q)
			ST_IDLE: begin
				if (req_valid) begin
					kind_d    = req_kind;
					io_out_d  = req_byte;
					io_oe_n_d = (req_kind == OP_RDATA); // R1
					cle_d     = (req_kind == OP_CMD); // R9 R16
					ale_d     = (req_kind == OP_ADDR); // R10 R16
					tmr_load  = 1'b1;
					tmr_val   = SETUP_LOAD;
					state_d   = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (tmr_expired) begin
					tmr_load = 1'b1;
					if (kind_q == OP_RDATA) begin
						rd_stb_n_d = 1'b0; // R6 R7
						tmr_val    = RD_LOW_LOAD;
					end else begin
						we_n_d  = 1'b0;
						tmr_val = WE_LOW_LOAD;
					end
					state_d = ST_STROBE;
				end
			end
			ST_STROBE: begin
				if (tmr_expired) begin
					tmr_load = 1'b1;
					tmr_val  = HOLD_LOAD;
					if (kind_q == OP_RDATA) begin
						// Sampled after the access delay has passed.
						rd_data_d  = shared_io_bus_in; // R6
						rd_valid_d = 1'b1;
						rd_stb_n_d = 1'b1;
					end else begin
						we_n_d = 1'b1; // R8
					end
					state_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// Latch enables and data stay put past the rising strobe edge.
				if (tmr_expired) begin
					cle_d     = 1'b0;
					ale_d     = 1'b0;
					io_oe_n_d = 1'b1;
					state_d   = ST_IDLE;
				end
			end
		endcase
		// Deselecting only between transfers lets the device drop to standby when idle.
		ce_n_d = !(chip_hold || req_valid || (state_d != ST_IDLE)); // R3 R4 R5
		wp_n_d = write_allow; // R11
		busy_d = !ready_busy_n; // R13 R14 R15
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_q    <= ST_IDLE;
			kind_q     <= OP_CMD;
			io_out_q   <= IO_RESET;
			io_oe_n_q  <= 1'b1;
			ce_n_q     <= 1'b1;
			rd_stb_n_q <= 1'b1;
			we_n_q     <= 1'b1;
			cle_q      <= 1'b0;
			ale_q      <= 1'b0;
			rd_valid_q <= 1'b0;
			rd_data_q  <= IO_RESET;
			wp_n_q     <= 1'b0; // R12
			busy_q     <= 1'b0;
		end else begin
			state_q    <= state_d;
			kind_q     <= kind_d;
			io_out_q   <= io_out_d;
			io_oe_n_q  <= io_oe_n_d;
			ce_n_q     <= ce_n_d;
			rd_stb_n_q <= rd_stb_n_d;
			we_n_q     <= we_n_d;
			cle_q      <= cle_d;
			ale_q      <= ale_d;
			rd_valid_q <= rd_valid_d;
			rd_data_q  <= rd_data_d;
			wp_n_q     <= wp_n_d;
			busy_q     <= busy_d;
		end
	end

	assign shared_io_bus_out  = io_out_q;
	assign shared_io_bus_oe_n = io_oe_n_q;
	assign chip_sel_n         = ce_n_q;
	assign read_strobe_n      = rd_stb_n_q;
	assign write_strobe_n     = we_n_q;
	assign cmd_latch          = cle_q;
	assign addr_latch         = ale_q;
	assign write_prot_n       = wp_n_q;
	assign rd_valid           = rd_valid_q;
	assign rd_data            = rd_data_q;
	assign busy               = busy_q;

	latch_excl_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R16
		!(cmd_latch && addr_latch))
		else $error("Both latch enables high together.");

	write_drive_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R1
		!write_strobe_n |-> (!shared_io_bus_oe_n && read_strobe_n))
		else $error("Bus not driven during a write strobe.");

	read_release_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R1
		!read_strobe_n |-> (shared_io_bus_oe_n && !cmd_latch && !addr_latch))
		else $error("Bus or latch enable active during a read strobe.");

	strobe_select_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R3
		(!write_strobe_n || !read_strobe_n) |-> !chip_sel_n)
		else $error("Strobe active while chip deselected.");

	we_width_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R8
		$fell(write_strobe_n) |-> !write_strobe_n [*2] ##1 write_strobe_n)
		else $error("Write strobe low width wrong.");

	rd_width_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R6
		$fell(read_strobe_n) |-> !read_strobe_n [*3] ##1 read_strobe_n)
		else $error("Read strobe low width wrong.");

	latch_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R9 R10
		$rose(write_strobe_n) |-> ($stable(cmd_latch) && $stable(addr_latch)
			&& $stable(shared_io_bus_out)) ##1 !shared_io_bus_oe_n)
		else $error("Latch enables or data moved at the write strobe rise.");

	rd_capture_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R6 R7
		rd_valid |-> ($past(read_strobe_n) == 1'b0 && read_strobe_n
			&& rd_data == $past(shared_io_bus_in)))
		else $error("Read byte not captured at the strobe end.");

	wp_follow_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R11 R12
		!write_allow |=> !write_prot_n)
		else $error("Write protect released without permission.");

	busy_track_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R14 R15
		(!ready_busy_n |=> busy) and (ready_busy_n |=> !busy))
		else $error("Busy flag does not follow the ready/busy pin.");

endmodule : nand_host

`default_nettype wire

// ### design/nand_host_pkg.sv
package nand_host_pkg;

	// Timing figures in nanoseconds and the clock period they are counted against.
	localparam int CLK_PERIOD_NS            = 10;
	localparam int SETUP_NS                 = 10;
	localparam int WE_LOW_NS                = 20;
	localparam int READ_DATA_VALID_DELAY_NS = 20;
	localparam int HOLD_NS                  = 20;

	// Least times round up to whole cycles.
	localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_DATA_VALID_DELAY_CYC =
		(READ_DATA_VALID_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// One extra cycle so the bus is sampled only after the delay has fully passed.
	localparam int RD_LOW_CYC = READ_DATA_VALID_DELAY_CYC + 1;
	localparam int HOLD_CYC   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int TIMER_W = 4;

	localparam logic [TIMER_W-1:0] SETUP_LOAD  = TIMER_W'(SETUP_CYC - 1);
	localparam logic [TIMER_W-1:0] WE_LOW_LOAD = TIMER_W'(WE_LOW_CYC - 1);
	localparam logic [TIMER_W-1:0] RD_LOW_LOAD = TIMER_W'(RD_LOW_CYC - 1);
	localparam logic [TIMER_W-1:0] HOLD_LOAD   = TIMER_W'(HOLD_CYC - 1);

	localparam logic [7:0] IO_RESET = 8'h00;

	typedef enum logic [1:0] {
		OP_CMD   = 2'h0,
		OP_ADDR  = 2'h1,
		OP_WDATA = 2'h2,
		OP_RDATA = 2'h3
	} op_kind_e;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'h1,
		ST_SETUP  = 4'h2,
		ST_STROBE = 4'h4,
		ST_HOLD   = 4'h8
	} state_e;

endpackage : nand_host_pkg

// ### design/phase_timer.sv
`timescale 1ns/1ps
`default_nettype none

module phase_timer
	import nand_host_pkg::*;
#(
	parameter int W = TIMER_W
) (
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              expired
);

	logic [W-1:0] count_q;
	logic [W-1:0] count_d;

	always_comb begin
		if (load) begin
			count_d = load_val;
		end else if (count_q != '0) begin
			count_d = count_q - W'(1);
		end else begin
			count_d = count_q;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

	assign expired = (count_q == '0);

	timer_load_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		load |=> (count_q == $past(load_val)))
		else $error("Phase timer did not take its load value.");

endmodule : phase_timer

`default_nettype wire

// ### verification/nand_dev_model.sv
`timescale 1ns/1ps
`default_nettype none

module nand_dev_model #(
	parameter int BUSY_NS = 300
) (
	input  wire logic       chip_sel_n,
	input  wire logic       read_strobe_n,
	input  wire logic       write_strobe_n,
	input  wire logic       cmd_latch,
	input  wire logic       addr_latch,
	input  wire logic       write_prot_n,
	input  wire logic [7:0] io_in,
	output logic [7:0]      dev_out,
	output logic            dev_oe,
	output logic            rb_low,
	output logic            standby,
	output logic [7:0]      last_cmd,
	output logic [7:0]      last_addr
);
	logic [7:0] mem [0:255];
	logic [7:0] col;
	initial begin
		dev_out = 8'h00;
		dev_oe = 1'b0;
		rb_low = 1'b0;
		standby = 1'b1;
		col = 8'h00;
	end
	always @(posedge write_strobe_n) if (!chip_sel_n) begin
		if (cmd_latch) begin
			last_cmd = io_in;
			if (io_in == 8'h30) begin
				rb_low = 1'b1;
				rb_low <= #(BUSY_NS) 1'b0;
			end
		end else if (addr_latch) begin
			last_addr = io_in;
			col = io_in;
		end else if (write_prot_n) begin
			mem[col] = io_in;
			col = col + 8'h01;
		end
	end
	// Until the access delay has run the lines show the inverse of the byte.
	always @(negedge read_strobe_n) if (!chip_sel_n) begin
		dev_oe = 1'b1;
		dev_out = ~mem[col];
		dev_out <= #20 mem[col];
		col = col + 8'h01;
	end
	always @(posedge read_strobe_n) begin
		dev_oe = 1'b0;
		dev_out = ~dev_out;
	end
	always @(posedge chip_sel_n) standby = !rb_low;
	always @(negedge chip_sel_n) standby = 1'b0;
endmodule : nand_dev_model

`default_nettype wire

// ### verification/nand_host_tb.sv
`timescale 1ns/1ps
`default_nettype none

module nand_host_tb;
	import nand_host_pkg::*;
	logic clk_sys, nrst, req_valid, req_ready, rd_valid, chip_hold, write_allow, busy;
	logic oe_n, cs_n, rd_stb_n, we_n, cle, ale, wp_n, dev_oe, rb_low, standby;
	logic [7:0] req_byte, rd_data, bus_out, bus_in, dev_out, last_cmd, last_addr, d;
	op_kind_e req_kind;
	int errors = 0;
	int checks = 0;
	// No pull on the data lines, so the model's released value stands in.
	assign bus_in = !oe_n ? bus_out : dev_out;
	nand_host uut (.clk_sys(clk_sys), .nrst(nrst), .req_valid(req_valid),
		.req_ready(req_ready), .req_kind(req_kind), .req_byte(req_byte),
		.rd_valid(rd_valid), .rd_data(rd_data), .chip_hold(chip_hold),
		.write_allow(write_allow), .busy(busy), .shared_io_bus_out(bus_out),
		.shared_io_bus_in(bus_in), .shared_io_bus_oe_n(oe_n), .chip_sel_n(cs_n),
		.read_strobe_n(rd_stb_n), .write_strobe_n(we_n), .cmd_latch(cle),
		.addr_latch(ale), .write_prot_n(wp_n), .ready_busy_n(!rb_low));
	nand_dev_model dev (.chip_sel_n(cs_n), .read_strobe_n(rd_stb_n), .write_strobe_n(we_n),
		.cmd_latch(cle), .addr_latch(ale), .write_prot_n(wp_n), .io_in(bus_in),
		.dev_out(dev_out), .dev_oe(dev_oe), .rb_low(rb_low), .standby(standby),
		.last_cmd(last_cmd), .last_addr(last_addr));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Whenever the model drives the lines, the host must have let go of them.
	always @(negedge clk_sys) begin
		if (dev_oe === 1'b1) begin
			check("host_release", {7'h00, oe_n}, 8'h01);
		end
	end
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic send(input op_kind_e kind, input logic [7:0] b, output logic [7:0] r);
		int n;
		int pulses;
		n = 0;
		pulses = 0;
		r = 8'h00;
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_kind = kind;
		req_byte = b;
		while (req_ready !== 1'b1 && n < 50) begin
			n++;
			@(negedge clk_sys);
		end
		check("req_ready", {7'h00, req_ready}, 8'h01);
		@(negedge clk_sys);
		req_valid = 1'b0;
		repeat (8) begin
			if (rd_valid === 1'b1) begin
				r = rd_data;
				pulses++;
			end
			@(negedge clk_sys);
		end
		check("rd_pulse", 8'(pulses), (kind == OP_RDATA) ? 8'h01 : 8'h00);
	endtask : send
	task automatic t_reset;
		check("sel", cs_n, 1'b1);
		check("wp", wp_n, 1'b0);
		check("strobes", {rd_stb_n, we_n}, 2'h3);
	endtask : t_reset
	task automatic t_write;
		@(negedge clk_sys);
		write_allow = 1'b1;
		send(OP_CMD, 8'h80, d);
		send(OP_ADDR, 8'h05, d);
		send(OP_WDATA, 8'hA5, d);
		send(OP_WDATA, 8'h3C, d);
		check("cmd", last_cmd, 8'h80);
		check("addr", last_addr, 8'h05);
		check("mem5", dev.mem[5], 8'hA5);
		check("mem6", dev.mem[6], 8'h3C);
	endtask : t_write
	task automatic t_read;
		chip_hold = 1'b1;
		send(OP_ADDR, 8'h05, d);
		send(OP_RDATA, 8'h00, d);
		check("rd0", d, 8'hA5);
		check("held", cs_n, 1'b0);
		send(OP_RDATA, 8'h00, d);
		check("rd1", d, 8'h3C);
		chip_hold = 1'b0;
	endtask : t_read
	task automatic t_protect;
		write_allow = 1'b0;
		send(OP_ADDR, 8'h05, d);
		send(OP_WDATA, 8'h11, d);
		check("prot", dev.mem[5], 8'hA5);
		write_allow = 1'b1;
	endtask : t_protect
	task automatic t_busy;
		int n;
		n = 0;
		send(OP_CMD, 8'h30, d);
		check("busy", busy, 1'b1);
		check("nostby", {cs_n, standby}, 2'h2);
		while (busy !== 1'b0 && n < 60) begin
			n++;
			@(negedge clk_sys);
		end
		check("ready", busy, 1'b0);
		send(OP_ADDR, 8'h05, d);
		send(OP_RDATA, 8'h00, d);
		check("stby", {cs_n, standby}, 2'h3);
	endtask : t_busy
	task automatic finish_test;
		if (errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	initial begin
		nrst = 1'b0;
		req_valid = 1'b0;
		req_kind = OP_CMD;
		req_byte = 8'h00;
		chip_hold = 1'b0;
		write_allow = 1'b0;
		repeat (4) @(negedge clk_sys);
		t_reset();
		nrst = 1'b1;
		t_write();
		t_read();
		t_protect();
		t_busy();
		finish_test();
	end
	initial begin
		#100000;
		errors++;
		finish_test();
	end
endmodule : nand_host_tb

`default_nettype wire
